// *** verilog/rtccr_regs.sv ***
`timescale 1ns/1ps
module rtccr_regs
    import rtccr_pkg::*;
#(
    parameter int PULSE_LEN = PULSE_TICKS
) (
    // clock and reset
    input  wire logic       mclk_i,
    input  wire logic       reset_n_i,
    // register byte port from the serial slave engine
    input  wire logic       byte_valid_i,
    input  wire logic       byte_is_ptr_i,
    input  wire logic [7:0] byte_data_i,
    input  wire logic       rd_req_i,
    output logic      [7:0] rd_data_o,
    output logic            access_inhibit_o,
    // supply state and pin settings
    input  wire logic       on_backup_i,
    input  wire logic       power_fail_i,
    input  wire logic       interrupt_control_i,
    // output pins
    output logic            int_n_o,
    output logic            int_oe_o,
    output logic            rst_n_o,
    output logic            rst_oe_o,
    output logic            square_wave_pin_o,
    output logic            square_wave_oe_o,
    output logic            osc_run_o,
    // trickle charger
    output logic            charger_enable_o,
    output logic            charger_diode_o,
    output logic      [1:0] charger_res_sel_o
);
    logic [7:0]  ctrl_r;
    logic        osf_r;
    logic        cd_flag_r;
    logic [7:0]  charger_r;
    logic [4:0]  ptr_r;
    logic [23:0] count_r;
    logic [23:0] seed_r;
    logic [23:0] seed_nxt;
    logic        expired_r;
    logic        pulse_int_r;
    logic        osc_run_d_r;
    logic        wr_en;
    logic        rd_en;
    logic        cnt_access;
    logic        cd_mode;
    logic        cd_active;
    logic        dec_tick;
    logic        zero_evt;
    logic        pulse_start;
    logic        pulse_busy;
    logic        pulse_done;
    logic        int_low;
    logic        osc_stop_evt;
    logic [7:0]  rd_nxt;

    rtccr_tick_if tick ();

    function automatic logic is_counter(input logic [4:0] addr);
        is_counter = (addr == REG_COUNT0) || (addr == REG_COUNT1) || (addr == REG_COUNT2);
    endfunction : is_counter

    function automatic logic [4:0] ptr_step(input logic [4:0] addr);
        ptr_step = (addr == REG_LAST) ? 5'h00 : addr + 5'h01;
    endfunction : ptr_step

    // oscillator always runs on main supply
    assign osc_run_o    = !(ctrl_r[CTL_OSC_DIS] && on_backup_i);
    assign osc_stop_evt = osc_run_d_r && !osc_run_o;
    assign tick.run     = osc_run_o;
    assign tick.rate    = {ctrl_r[CTL_RATE_HI], ctrl_r[CTL_RATE_LO]};

    rtccr_divider u_div (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .tb        (tick)
    );

    rtccr_pulse_timer #(
        .TICKS (PULSE_LEN)
    ) u_pulse (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .start_i   (pulse_start),
        .tick_i    (tick.tick_base),
        .busy_o    (pulse_busy),
        .done_o    (pulse_done)
    );

    // a reset-steered pulse locks out the register port
    assign access_inhibit_o = power_fail_i || (pulse_busy && !pulse_int_r);
    assign wr_en      = byte_valid_i && !byte_is_ptr_i && !access_inhibit_o;
    assign rd_en      = rd_req_i && !access_inhibit_o;
    assign cnt_access = (wr_en || rd_en) && is_counter(ptr_r);

    // pointer load and auto-increment
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ptr_r <= 5'h00;
        end else if (byte_valid_i && byte_is_ptr_i && !access_inhibit_o) begin
            ptr_r <= byte_data_i[4:0];
        end else if (wr_en || rd_en) begin
            ptr_r <= ptr_step(ptr_r);
        end
    end

    // writes land on the byte strobe, so new settings apply from the next cycle
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_r <= CONTROL_RST;
        end else if (wr_en && ptr_r == REG_CONTROL) begin
            ctrl_r <= byte_data_i;
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            charger_r <= CHARGER_RST;
        end else if (wr_en && ptr_r == REG_CHARGER) begin
            charger_r <= byte_data_i;
        end
    end

    assign charger_enable_o = (charger_r[7:4] == CHG_KEY)
                            && (charger_r[3:2] == CHG_NO_DIODE || charger_r[3:2] == CHG_ONE_DIODE)
                            && (charger_r[1:0] != CHG_RES_OFF);
    assign charger_diode_o   = charger_enable_o && (charger_r[3:2] == CHG_ONE_DIODE);
    assign charger_res_sel_o = charger_enable_o ? charger_r[1:0] : CHG_RES_OFF;

    // countdown datapath
    assign cd_mode   = ctrl_r[CTL_CD_MODE];
    assign cd_active = ctrl_r[CTL_CD_EN] && (seed_r != 24'h000000);
    assign dec_tick  = cd_mode ? tick.tick_wd : tick.tick_sec;
    assign zero_evt  = cd_active && dec_tick && !(cd_mode && expired_r) && !pulse_busy
                     && (count_r <= 24'h000001) && !cnt_access;

    always_comb begin
        seed_nxt = seed_r;
        if (ptr_r == REG_COUNT0) begin
            seed_nxt[7:0] = byte_data_i;
        end else if (ptr_r == REG_COUNT1) begin
            seed_nxt[15:8] = byte_data_i;
        end else begin
            seed_nxt[23:16] = byte_data_i;
        end
    end

    // a write during an interrupt pulse reloads but counting resumes after it
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            seed_r    <= 24'h000000;
            count_r   <= 24'h000000;
            expired_r <= 1'b0;
        end else if (wr_en && is_counter(ptr_r)) begin
            seed_r    <= seed_nxt;
            count_r   <= seed_nxt;
            expired_r <= 1'b0;
        end else if (rd_en && is_counter(ptr_r) && cd_mode && !expired_r) begin
            count_r <= seed_r;
        end else if (zero_evt && cd_mode) begin
            count_r   <= 24'h000000;
            expired_r <= 1'b1;
        end else if (zero_evt) begin
            count_r <= seed_r;
        end else if (cd_active && dec_tick && !(cd_mode && expired_r) && !pulse_busy) begin
            count_r <= count_r - 24'h000001;
        end
    end

    // timeout pulse goes to the reset pin unless steered to interrupt
    assign pulse_start = zero_evt && cd_mode
                       && (!ctrl_r[CTL_STEER] || (ctrl_r[CTL_FLAG_IE] && interrupt_control_i));

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pulse_int_r <= 1'b0;
        end else if (pulse_start) begin
            pulse_int_r <= ctrl_r[CTL_STEER];
        end
    end

    // hardware set beats a software clear in the same cycle
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cd_flag_r <= 1'b0;
        end else if (zero_evt) begin
            cd_flag_r <= 1'b1;
        end else if (pulse_done) begin
            cd_flag_r <= 1'b0;
        end else if (wr_en && ptr_r == REG_STATUS && !byte_data_i[STS_CD_FLAG]) begin
            cd_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            osf_r       <= OSF_RST;
            osc_run_d_r <= 1'b1;
        end else begin
            osc_run_d_r <= osc_run_o;
            if (osc_stop_evt) begin
                osf_r <= 1'b1;
            end else if (wr_en && ptr_r == REG_STATUS && !byte_data_i[STS_OSF]) begin
                osf_r <= 1'b0;
            end
        end
    end

    // pulse timer alone ends a pulse; register writes cannot cut it short
    assign int_low = (pulse_busy && pulse_int_r)
                   || (!cd_mode && ctrl_r[CTL_FLAG_IE] && interrupt_control_i && cd_flag_r);
    // no supply term in the interrupt path
    assign int_oe_o = int_low;
    assign int_n_o  = !int_low;
    assign rst_oe_o = pulse_busy && !pulse_int_r;
    assign rst_n_o  = !rst_oe_o;

    assign square_wave_pin_o = tick.square_wave_pin;
    assign square_wave_oe_o  = !power_fail_i || ctrl_r[CTL_BACKUP_SQUARE_WAVE_ENABLE];

    always_comb begin
        rd_nxt = 8'h00;
        if (ptr_r == REG_COUNT0) begin
            rd_nxt = count_r[7:0];
        end else if (ptr_r == REG_COUNT1) begin
            rd_nxt = count_r[15:8];
        end else if (ptr_r == REG_COUNT2) begin
            rd_nxt = count_r[23:16];
        end else if (ptr_r == REG_CONTROL) begin
            rd_nxt = ctrl_r;
        end else if (ptr_r == REG_STATUS) begin
            rd_nxt[STS_OSF]     = osf_r;
            rd_nxt[STS_CD_FLAG] = cd_flag_r;
        end else if (ptr_r == REG_CHARGER) begin
            rd_nxt = charger_r;
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_data_o <= 8'h00;
        end else if (rd_en) begin
            rd_data_o <= rd_nxt;
        end
    end

    int_gate_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        !interrupt_control_i && !(pulse_busy && pulse_int_r) |-> !int_oe_o)
        else $error("interrupt asserted without interrupt control");

    flag_write_one_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        cd_flag_r && wr_en && ptr_r == REG_STATUS && byte_data_i[STS_CD_FLAG] && !pulse_done |=> cd_flag_r)
        else $error("writing one altered countdown flag");

    osf_sticky_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        osc_stop_evt |=> osf_r)
        else $error("oscillator stop not flagged");

    rst_steer_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        pulse_start && !ctrl_r[CTL_STEER] |=> (rst_oe_o && !int_oe_o)[*2])
        else $error("timeout pulse not on reset pin");

    wd_stop_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        zero_evt && cd_mode |=> count_r == 24'h000000 && expired_r && cd_flag_r)
        else $error("watchdog did not stop and flag");

    alarm_reload_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        zero_evt && !cd_mode |=> count_r == $past(seed_r) && cd_flag_r)
        else $error("alarm did not reload");

    pulse_hold_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        pulse_busy && pulse_int_r && !pulse_done && wr_en && ptr_r == REG_CONTROL |=> int_oe_o)
        else $error("interrupt pulse cut short by write");

    wd_access_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        rd_en && is_counter(ptr_r) && cd_mode && !expired_r |=> count_r == $past(seed_r))
        else $error("counter access did not reload");

    pulse_end_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        pulse_done && pulse_int_r |=> !cd_flag_r && !int_oe_o)
        else $error("flag not cleared at pulse end");

    storage_hold_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        !ctrl_r[CTL_CD_EN] && !cnt_access |=> count_r == $past(count_r))
        else $error("disabled counter changed");
endmodule : rtccr_regs

// *** verilog/rtccr_pkg.sv ***
// constants shared by the countdown control register bank
package rtccr_pkg;
    // register byte offsets
    localparam logic [4:0] REG_COUNT0  = 5'h04;
    localparam logic [4:0] REG_COUNT1  = 5'h05;
    localparam logic [4:0] REG_COUNT2  = 5'h06;
    localparam logic [4:0] REG_CONTROL = 5'h07;
    localparam logic [4:0] REG_STATUS  = 5'h08;
    localparam logic [4:0] REG_CHARGER = 5'h10;
    localparam logic [4:0] REG_LAST    = 5'h10;

    // timer_control fields
    localparam int CTL_OSC_DIS  = 7;
    localparam int CTL_CD_EN    = 6;
    localparam int CTL_CD_MODE  = 5;
    localparam int CTL_BACKUP_SQUARE_WAVE_ENABLE    = 4;
    localparam int CTL_STEER    = 3;
    localparam int CTL_RATE_HI  = 2;
    localparam int CTL_RATE_LO  = 1;
    localparam int CTL_FLAG_IE  = 0;

    // flag_status fields
    localparam int STS_OSF      = 7;
    localparam int STS_CD_FLAG  = 0;

    // charger_config fields and key
    localparam logic [3:0] CHG_KEY      = 4'hA;
    localparam logic [1:0] CHG_NO_DIODE = 2'h1;
    localparam logic [1:0] CHG_ONE_DIODE = 2'h2;
    localparam logic [1:0] CHG_RES_OFF  = 2'h0;

    // reset values
    localparam logic [7:0] CONTROL_RST = 8'h06;
    localparam logic       OSF_RST     = 1'b1;
    localparam logic [7:0] CHARGER_RST = 8'h00;

    // timing
    localparam int CLK_HZ       = 25000000;
    localparam int BASE_HZ      = 65536;
    localparam int PRESCALE_CYC = CLK_HZ / BASE_HZ;
    localparam int PULSE_MS     = 250;
    localparam int PULSE_TICKS  = PULSE_MS * BASE_HZ / 1000;
    localparam int DIV_BITS     = 16;
    localparam int WD_DIV_BITS  = 4;

    // square-wave rate codes
    localparam logic [1:0] RATE_1HZ   = 2'h0;
    localparam logic [1:0] RATE_4K    = 2'h1;
    localparam logic [1:0] RATE_8K    = 2'h2;
    localparam logic [1:0] RATE_32K   = 2'h3;
endpackage : rtccr_pkg

// *** verilog/rtccr_tick_if.sv ***
// time base signals between divider and register bank
`timescale 1ns/1ps
interface rtccr_tick_if;
    logic       run;
    logic [1:0] rate;
    logic       tick_base;
    logic       tick_wd;
    logic       tick_sec;
    logic       square_wave_pin;
    modport gen (input run, input rate, output tick_base, output tick_wd, output tick_sec, output square_wave_pin);
    modport use_ (output run, output rate, input tick_base, input tick_wd, input tick_sec, input square_wave_pin);
endinterface : rtccr_tick_if

// *** verilog/rtccr_divider.sv ***
// oscillator time base: prescaler, binary chain and square-wave select
`timescale 1ns/1ps
module rtccr_divider
    import rtccr_pkg::*;
(
    // clock and reset
    input  wire logic mclk_i,
    input  wire logic reset_n_i,
    // time base
    rtccr_tick_if.gen tb
);
    logic [8:0]          pre_r;
    logic [DIV_BITS-1:0] div_r;
    logic                base_w;
    logic                sqw_nxt;

    assign base_w       = tb.run && (pre_r == 9'(PRESCALE_CYC - 1));
    assign tb.tick_base = base_w;
    assign tb.tick_wd   = base_w && (div_r[WD_DIV_BITS-1:0] == {WD_DIV_BITS{1'b1}});
    assign tb.tick_sec  = base_w && (div_r == {DIV_BITS{1'b1}});

    // stopped oscillator freezes the whole chain
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pre_r <= 9'h000;
        end else if (!tb.run) begin
            pre_r <= pre_r;
        end else if (base_w) begin
            pre_r <= 9'h000;
        end else begin
            pre_r <= pre_r + 9'h001;
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            div_r <= '0;
        end else if (base_w) begin
            div_r <= div_r + 1'b1;
        end
    end

    always_comb begin
        case (tb.rate)
            RATE_1HZ: sqw_nxt = div_r[DIV_BITS-1];
            RATE_4K:  sqw_nxt = div_r[3];
            RATE_8K:  sqw_nxt = div_r[2];
            default:  sqw_nxt = div_r[0];
        endcase
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tb.square_wave_pin <= 1'b0;
        end else begin
            tb.square_wave_pin <= sqw_nxt;
        end
    end
endmodule : rtccr_divider

// *** verilog/rtccr_pulse_timer.sv ***
// fixed-length output pulse timed in time base ticks
`timescale 1ns/1ps
module rtccr_pulse_timer #(
    parameter int TICKS = 16384
) (
    // clock and reset
    input  wire logic mclk_i,
    input  wire logic reset_n_i,
    // control
    input  wire logic start_i,
    input  wire logic tick_i,
    output logic      busy_o,
    output logic      done_o
);
    logic [15:0] left_r;

    assign done_o = busy_o && tick_i && (left_r == 16'h0001);

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            busy_o <= 1'b0;
            left_r <= 16'h0000;
        end else if (start_i && !busy_o) begin
            busy_o <= 1'b1;
            left_r <= 16'(TICKS);
        end else if (done_o) begin
            busy_o <= 1'b0;
            left_r <= 16'h0000;
        end else if (busy_o && tick_i) begin
            left_r <= left_r - 16'h0001;
        end
    end
endmodule : rtccr_pulse_timer

// *** tb/rtccr_engine_model.sv ***
// byte port driver standing in for the serial slave engine
`timescale 1ns/1ps
module rtccr_engine_model (
    // clock
    input  wire logic       mclk_i,
    // register byte port
    output logic            byte_valid_o,
    output logic            byte_is_ptr_o,
    output logic      [7:0] byte_data_o,
    output logic            rd_req_o,
    input  wire logic [7:0] rd_data_i,
    input  wire logic       access_inhibit_i
);
    initial begin
        byte_valid_o  = 1'b0;
        byte_is_ptr_o = 1'b0;
        byte_data_o   = 8'h5A;
        rd_req_o      = 1'b0;
    end

    // inhibit is sampled before the edge, as the bank sees it
    task automatic wait_taken;
        logic inh;
        int   n;
        n   = 0;
        inh = 1'b1;
        while (inh && n < 8000) begin
            @(negedge mclk_i);
            inh = access_inhibit_i;
            @(posedge mclk_i);
            n++;
        end
    endtask : wait_taken

    // pointer byte first, data bytes after it post-increment
    task automatic send_byte(input logic ptr, input logic [7:0] data);
        @(posedge mclk_i);
        byte_valid_o  <= 1'b1;
        byte_is_ptr_o <= ptr;
        byte_data_o   <= data;
        wait_taken();
        byte_valid_o  <= 1'b0;
        byte_is_ptr_o <= 1'b0;
        // idle data lines must not keep the last byte
        byte_data_o   <= ~data;
    endtask : send_byte

    task automatic read_next(output logic [7:0] data);
        @(posedge mclk_i);
        rd_req_o <= 1'b1;
        wait_taken();
        rd_req_o <= 1'b0;
        #1;
        data = rd_data_i;
    endtask : read_next
endmodule : rtccr_engine_model

// *** tb/testbench.sv ***
// self-checking bench for the countdown control register bank
`timescale 1ns/1ps
module testbench;
    import rtccr_pkg::*;
    localparam int BT   = PRESCALE_CYC;  // cycles per base tick
    localparam int CEIL = 98000;
    // stimulus
    logic       mclk_i              = 1'b0;
    logic       reset_n_i           = 1'b0;
    logic       on_backup_i         = 1'b0;
    logic       power_fail_i        = 1'b0;
    logic       interrupt_control_i = 1'b0;
    // byte port and outputs
    logic       byte_valid, byte_is_ptr, rd_req, access_inhibit_o;
    logic [7:0] byte_data, rd_data_o;
    logic       int_n_o, int_oe_o, rst_n_o, rst_oe_o, square_wave_pin_o, square_wave_oe_o, osc_run_o;
    logic       charger_enable_o, charger_diode_o;
    logic [1:0] charger_res_sel_o;
    int         mismatches = 0;
    int         checks     = 0;
    int         cycles     = 0;
    logic [7:0] d;
    int         n;

    rtccr_regs #(.PULSE_LEN(4)) u_rtccr_regs (
        .mclk_i(mclk_i), .reset_n_i(reset_n_i),
        .byte_valid_i(byte_valid), .byte_is_ptr_i(byte_is_ptr), .byte_data_i(byte_data),
        .rd_req_i(rd_req), .rd_data_o(rd_data_o), .access_inhibit_o(access_inhibit_o),
        .on_backup_i(on_backup_i), .power_fail_i(power_fail_i), .interrupt_control_i(interrupt_control_i),
        .int_n_o(int_n_o), .int_oe_o(int_oe_o), .rst_n_o(rst_n_o), .rst_oe_o(rst_oe_o),
        .square_wave_pin_o(square_wave_pin_o), .square_wave_oe_o(square_wave_oe_o), .osc_run_o(osc_run_o),
        .charger_enable_o(charger_enable_o), .charger_diode_o(charger_diode_o),
        .charger_res_sel_o(charger_res_sel_o)
    );

    rtccr_engine_model u_rtccr_engine_model (
        .mclk_i(mclk_i), .byte_valid_o(byte_valid), .byte_is_ptr_o(byte_is_ptr), .byte_data_o(byte_data),
        .rd_req_o(rd_req), .rd_data_i(rd_data_o), .access_inhibit_i(access_inhibit_o)
    );

    always #20 mclk_i = ~mclk_i;

    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (cycles == CEIL) begin
            mismatches++;
            give_verdict();
        end
    end

    task automatic give_verdict;
        if (mismatches == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        u_rtccr_engine_model.send_byte(1'b1, {3'h0, a});
        u_rtccr_engine_model.send_byte(1'b0, v);
    endtask : wr

    task automatic rd(input logic [4:0] a, output logic [7:0] v);
        u_rtccr_engine_model.send_byte(1'b1, {3'h0, a});
        u_rtccr_engine_model.read_next(v);
    endtask : rd

    // seed of two watchdog ticks, least significant byte first
    task automatic seed_two;
        wr(REG_COUNT0, 8'h02);
        u_rtccr_engine_model.send_byte(1'b0, 8'h00);
        u_rtccr_engine_model.send_byte(1'b0, 8'h00);
    endtask : seed_two

    function automatic logic pin(input bit on_int);
        return on_int ? int_oe_o : rst_oe_o;
    endfunction : pin

    task automatic wait_pin(input bit on_int, input logic lvl, input int limit, output int k);
        k = 0;
        while (pin(on_int) !== lvl && k < limit) begin
            @(posedge mclk_i);
            #1;
            k++;
        end
    endtask : wait_pin

    task automatic s_reset;
        rd(REG_CONTROL, d); check(d, 8'h06);
        rd(REG_STATUS, d); check(d, 8'h80);
        rd(REG_CHARGER, d); check(d, 8'h00);
        check({charger_enable_o, int_oe_o, rst_oe_o, osc_run_o}, 4'h1);
    endtask : s_reset

    task automatic s_storage;
        wr(REG_COUNT0, 8'h11);
        u_rtccr_engine_model.send_byte(1'b0, 8'h22);
        u_rtccr_engine_model.send_byte(1'b0, 8'h33);
        u_rtccr_engine_model.send_byte(1'b1, 8'h04);
        for (int i = 0; i < 3; i++) begin
            u_rtccr_engine_model.read_next(d); check(d, 8'h11 * (i + 1));
        end
        u_rtccr_engine_model.read_next(d); check(d, 8'h06);
        wr(REG_STATUS, 8'hFF); rd(REG_STATUS, d); check(d, 8'h80);
        wr(REG_STATUS, 8'h00); rd(REG_STATUS, d); check(d, 8'h00);
    endtask : s_storage

    task automatic s_charger;
        logic [9:0] tbl [9] = '{{8'hA5, 2'b10}, {8'hAA, 2'b11}, {8'hAB, 2'b11}, {8'hA6, 2'b10},
                                {8'hAF, 2'b00}, {8'hA4, 2'b00}, {8'hA1, 2'b00}, {8'h55, 2'b00}, {8'hB5, 2'b00}};
        foreach (tbl[i]) begin
            wr(REG_CHARGER, tbl[i][9:2]);
            rd(REG_CHARGER, d); check(d, tbl[i][9:2]);
            check(charger_enable_o, tbl[i][1]);
            if (tbl[i][1]) begin
                check(charger_diode_o, tbl[i][0]);
                check(charger_res_sel_o, tbl[i][3:2]);
            end
        end
    endtask : s_charger

    task automatic s_power;
        int t0;
        wr(REG_CONTROL, 8'h96);
        #1; check(osc_run_o, 1'b1);
        @(posedge mclk_i); on_backup_i <= 1'b1;
        @(posedge mclk_i); #1; check(osc_run_o, 1'b0);
        rd(REG_STATUS, d); check(d[7], 1'b1);
        @(posedge mclk_i); on_backup_i <= 1'b0; power_fail_i <= 1'b1;
        @(posedge mclk_i); #1; check(square_wave_oe_o, 1'b1);
        @(posedge mclk_i); power_fail_i <= 1'b0;
        wr(REG_CONTROL, 8'h06);
        @(posedge mclk_i); power_fail_i <= 1'b1;
        @(posedge mclk_i); #1; check(square_wave_oe_o, 1'b0);
        @(posedge mclk_i); power_fail_i <= 1'b0;
        for (int r = 0; r < 4; r++) begin
            wr(REG_CONTROL, {5'h00, 2'(3 - r), 1'b0});
            rd(REG_CONTROL, d); check(d, {5'h00, 2'(3 - r), 1'b0});
            if (r < 2) begin
                @(posedge square_wave_pin_o);
                t0 = $time;
                @(posedge square_wave_pin_o);
                check(($time - t0) / 40, r ? 8 * BT : 2 * BT);
            end
        end
    endtask : s_power

    task automatic s_wd_reset;
        wr(REG_STATUS, 8'h00);
        seed_two();
        wr(REG_CONTROL, 8'h66);
        wait_pin(1'b0, 1'b1, 14000, n); check(n >= 6000 && n <= 12300, 1'b1);
        check({int_oe_o, rst_n_o, access_inhibit_o}, 3'b001);
        wait_pin(1'b0, 1'b0, 3000, n); check(n >= 3 * BT && n <= 5 * BT, 1'b1);
        rd(REG_STATUS, d); check(d[0], 1'b0);
        wait_pin(1'b0, 1'b1, 7000, n); check(n, 7000);
    endtask : s_wd_reset

    task automatic s_wd_int;
        int t0;
        @(posedge mclk_i); interrupt_control_i <= 1'b1;
        seed_two();
        wr(REG_CONTROL, 8'h6F);
        wait_pin(1'b1, 1'b1, 14000, n); check({rst_oe_o, int_n_o}, 2'b00);
        t0 = $time;
        wr(REG_CONTROL, 8'h6E);
        wr(REG_STATUS, 8'h00);
        wait_pin(1'b1, 1'b0, 3000, n); check(($time - t0) / 40 >= 3 * BT, 1'b1);
        rd(REG_STATUS, d); check(d[0], 1'b0);
        @(posedge mclk_i); interrupt_control_i <= 1'b0;
        seed_two();
        wr(REG_CONTROL, 8'h6F);
        wait_pin(1'b1, 1'b1, 13000, n); check(n, 13000);
        rd(REG_STATUS, d); check(d[0], 1'b1);
        wr(REG_STATUS, 8'h01); rd(REG_STATUS, d); check(d[0], 1'b1);
        wr(REG_STATUS, 8'h00); rd(REG_STATUS, d); check(d[0], 1'b0);
    endtask : s_wd_int

    // reads keep a short watchdog from expiring until they stop, then it expires
    task automatic s_wd_reload;
        @(posedge mclk_i); interrupt_control_i <= 1'b1;
        seed_two();
        wr(REG_CONTROL, 8'h6E);
        repeat (3) begin
            repeat (3000) @(posedge mclk_i);
            rd(REG_COUNT0, d);
        end
        rd(REG_STATUS, d); check(d[0], 1'b0);
        repeat (12500) @(posedge mclk_i);
        rd(REG_STATUS, d); check(d[0], 1'b1);
    endtask : s_wd_reload

    initial begin
        repeat (2) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        s_reset();
        s_storage();
        s_charger();
        s_power();
        s_wd_reset();
        s_wd_int();
        s_wd_reload();
        give_verdict();
    end
endmodule : testbench
